// ===== rtl/instr_exec_regs.vh
// Constants for the instruction execution subset: operation codes,
// field positions, widths and reset values.
// Included by the execution core, its property module and the testbench.
`ifndef INSTR_EXEC_REGS_VH
`define INSTR_EXEC_REGS_VH

// Operation select codes on op_sel
`define OP_CLEAR_WATCHDOG    3'h0
`define OP_CALL              3'h1
`define OP_COMPLEMENT_REG    3'h2
`define OP_CLEAR_REG         3'h3
`define OP_CLEAR_ACCUM       3'h4
`define OP_DECREMENT_REG     3'h5
`define OP_DECREMENT_SKIP    3'h6
`define OP_NO_OPERATION      3'h7

// Destination bit values
`define DEST_ACCUM           1'h0
`define DEST_FILE            1'h1

// Widths and field positions
`define DATA_W               8
`define FILE_ADDR_W          7
`define PC_W                 13
`define CALL_TARGET_W        11
`define PC_LATCH_W           5
`define PC_LATCH_PAGE_HI     4
`define PC_LATCH_PAGE_LO     3
`define STACK_DEPTH          8
`define STACK_PTR_W          3

// Values
`define DATA_ZERO            8'h00
`define DATA_ONE             8'h01
`define PC_RESET             13'h0000
`define PC_STEP              13'h0001
`define STACK_PTR_STEP       3'h1
`define ACCUM_RESET          8'h00
`define ZERO_FLAG_RESET      1'h0
`define TIMEOUT_FLAG_RESET   1'h1
`define POWERDOWN_FLAG_RESET 1'h1

`endif

// ===== rtl/return_stack_mem.v
// Small memory holding the hardware return stack entries.
// One write port, one read port; read data comes out of a register and
// a write to the address being read passes straight through.
`timescale 1ns/1ns

module return_stack_mem #(
    parameter WIDTH  = 13,
    parameter DEPTH  = 8,
    parameter ADDR_W = 3
) (
    input  wire              clk,
    input  wire              resetn,
    input  wire              wr_en,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [WIDTH-1:0]  wr_data,
    input  wire [ADDR_W-1:0] rd_addr,
    output reg  [WIDTH-1:0]  rd_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [DEPTH-1:0] written;

    // Storage array, no reset needed on the contents
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, write-through so a fresh push shows at once
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= {WIDTH{1'b0}};
        end else if (wr_en && (wr_addr == rd_addr)) begin
            rd_data <= wr_data;
        end else if (written[rd_addr]) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= {WIDTH{1'b0}}; // Never shows an unwritten slot
        end
    end

    // Slots pushed since reset; the contents themselves carry no reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            written <= {DEPTH{1'b0}};
        end else if (wr_en) begin
            written[wr_addr] <= 1'b1;
        end
    end

endmodule // return_stack_mem

// ===== rtl/instr_exec_core.v
// Execution unit for seven core operations: watchdog clear, subroutine
// call, complement, clear register, clear accumulator, decrement and
// decrement-skip-if-zero.
// Assumes the decoder presents one operation per cycle on op_valid with
// the file register contents already read onto file_rd_data, all on clk.
// The watchdog, the register file and the page latch sit outside; this block
// holds the status flags, drives the clear and write terms and only reads the latch.
// No pop path exists here: returns belong to another unit.
`timescale 1ns/1ns
`include "instr_exec_regs.vh"

module instr_exec_core #(
    parameter STACK_DEPTH = `STACK_DEPTH,
    parameter STACK_PTR_W = `STACK_PTR_W
) (
    input  wire                      clk,
    input  wire                      resetn,
    input  wire                      op_valid,
    input  wire [2:0]                op_sel,
    input  wire                      dest_bit,
    input  wire [`FILE_ADDR_W-1:0]   file_addr,
    input  wire [`DATA_W-1:0]        file_rd_data,
    input  wire [`CALL_TARGET_W-1:0] call_target,
    input  wire [`PC_LATCH_W-1:0]    pc_high_latch,
    output reg  [`DATA_W-1:0]        working_accumulator,
    output reg                       file_wr_en,
    output reg  [`FILE_ADDR_W-1:0]   file_wr_addr,
    output reg  [`DATA_W-1:0]        file_wr_data,
    output reg                       zero_flag,
    output reg                       timeout_flag,
    output reg                       powerdown_flag,
    output reg                       watchdog_clear,
    output reg  [`PC_W-1:0]          program_counter,
    output wire [`PC_W-1:0]          stack_top,
    output reg  [STACK_PTR_W-1:0]    stack_level,
    output reg                       second_cycle,
    output reg                       op_done
);

    // Second-cycle kinds
    localparam SECOND_NONE = 2'h0;
    localparam SECOND_CALL = 2'h1;
    localparam SECOND_SKIP = 2'h2;

    // One for a zero byte; used by the complement and decrement flag updates and the skip test
    function is_zero;
        input [`DATA_W-1:0] value;
        begin
            is_zero = (value == `DATA_ZERO);
        end
    endfunction

    // Decode helper: does this operation honour the destination bit
    function uses_dest;
        input [2:0] sel;
        begin
            uses_dest = (sel == `OP_COMPLEMENT_REG) ||
                        (sel == `OP_DECREMENT_REG)  ||
                        (sel == `OP_DECREMENT_SKIP);
        end
    endfunction

    reg  [1:0]             second_kind;
    reg  [1:0]             next_second_kind;
    reg  [`DATA_W-1:0]     next_result;
    reg                    next_result_valid;
    reg                    next_zero_update;
    reg                    next_zero_value;
    reg                    next_watchdog_clear;
    reg                    next_status_set;
    reg                    next_push;
    // Destination routing decided in the decode, applied at the edge
    reg                    next_file_write;
    reg                    next_accum_write;
    reg  [`PC_W-1:0]       next_pc;
    reg  [STACK_PTR_W-1:0] stack_ptr;
    wire [STACK_PTR_W-1:0] stack_rd_addr;
    wire                   accept;
    wire [`DATA_W-1:0]     dec_value;
    wire [`PC_W-1:0]       return_addr;
    wire [`PC_W-1:0]       call_dest;

    // An operation offered during a second cycle is the discarded one
    assign accept      = op_valid && !second_cycle;
    assign dec_value   = file_rd_data - `DATA_ONE;
    assign return_addr = program_counter + `PC_STEP;
    // Upper bits come from the latch, low eleven from the operand
    assign call_dest   = {pc_high_latch[`PC_LATCH_PAGE_HI:`PC_LATCH_PAGE_LO],
                          call_target};

    // Read the newest entry; during a push read the slot being written
    assign stack_rd_addr = next_push ? stack_ptr : (stack_ptr - `STACK_PTR_STEP);

    // Result, flag and control decode for the accepted operation
    always @* begin
        next_result         = `DATA_ZERO;
        next_result_valid   = 1'b0;
        next_zero_update    = 1'b0;
        next_zero_value     = 1'b0;
        next_watchdog_clear = 1'b0;
        next_status_set     = 1'b0;
        next_push           = 1'b0;
        next_file_write     = 1'b0;
        next_accum_write    = 1'b0;
        next_second_kind    = SECOND_NONE;
        next_pc             = program_counter;
        if (accept) begin
            next_pc = program_counter + `PC_STEP;
            case (op_sel)
                `OP_CLEAR_WATCHDOG: begin
                    next_watchdog_clear = 1'b1;
                    next_status_set     = 1'b1;
                end
                `OP_CALL: begin
                    next_push        = 1'b1;
                    next_pc          = call_dest;
                    next_second_kind = SECOND_CALL;
                end
                `OP_COMPLEMENT_REG: begin
                    next_result       = ~file_rd_data;
                    next_result_valid = 1'b1;
                    next_zero_update  = 1'b1;
                    next_zero_value   = is_zero(~file_rd_data);
                end
                `OP_CLEAR_REG: begin
                    next_result       = `DATA_ZERO;
                    next_result_valid = 1'b1;
                    next_zero_update  = 1'b1;
                    next_zero_value   = 1'b1;
                end
                `OP_CLEAR_ACCUM: begin
                    next_result       = `DATA_ZERO;
                    next_result_valid = 1'b1;
                    next_zero_update  = 1'b1;
                    next_zero_value   = 1'b1;
                end
                `OP_DECREMENT_REG: begin
                    next_result       = dec_value;
                    next_result_valid = 1'b1;
                    next_zero_update  = 1'b1;
                    next_zero_value   = is_zero(dec_value);
                end
                `OP_DECREMENT_SKIP: begin
                    next_result       = dec_value;
                    next_result_valid = 1'b1;
                    if (is_zero(dec_value)) begin
                        next_second_kind = SECOND_SKIP;
                    end
                end
                default: begin
                    next_result_valid = 1'b0;
                end
            endcase
            // Fixed targets first; clear register ignores the d bit
            if (next_result_valid) begin
                if (op_sel == `OP_CLEAR_ACCUM) begin
                    next_accum_write = 1'b1;
                end else if ((op_sel == `OP_CLEAR_REG) ||
                             (uses_dest(op_sel) && (dest_bit == `DEST_FILE))) begin
                    next_file_write = 1'b1;
                end else begin
                    next_accum_write = 1'b1;
                end
            end
        end
    end

    // Accumulator and file register write port
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            working_accumulator <= `ACCUM_RESET;
            file_wr_en          <= 1'b0;
            file_wr_addr        <= {`FILE_ADDR_W{1'b0}};
            file_wr_data        <= `DATA_ZERO;
        end else begin
            // Strobe lasts one cycle; address and data hold until the next write
            file_wr_en <= 1'b0;
            if (next_accum_write) begin
                working_accumulator <= next_result;
            end
            if (next_file_write) begin
                file_wr_en   <= 1'b1;
                file_wr_addr <= file_addr;
                file_wr_data <= next_result;
            end
        end
    end

    // Status flags; call and decrement-skip never reach these terms
    // Set-only: clearing timeout and powerdown belongs to sleep logic
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            zero_flag      <= `ZERO_FLAG_RESET;
            timeout_flag   <= `TIMEOUT_FLAG_RESET;
            powerdown_flag <= `POWERDOWN_FLAG_RESET;
        end else begin
            if (next_zero_update) begin
                zero_flag <= next_zero_value;
            end
            if (next_status_set) begin
                timeout_flag   <= 1'b1;
                powerdown_flag <= 1'b1;
            end
        end
    end

    // Watchdog clear pulse, one cycle, clears counter and prescaler
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            watchdog_clear <= 1'b0;
        end else begin
            watchdog_clear <= next_watchdog_clear;
        end
    end

    // Program counter: one step per taken op, call loads, skip steps again
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            program_counter <= `PC_RESET;
        end else if (second_cycle) begin
            case (second_kind)
                SECOND_SKIP: begin
                    // The discarded slot is passed over, not executed
                    program_counter <= program_counter + `PC_STEP;
                end
                SECOND_CALL: begin
                    program_counter <= program_counter;
                end
                default: begin
                    program_counter <= program_counter;
                end
            endcase
        end else if (accept) begin
            program_counter <= next_pc;
        end
    end

    // Second-cycle sequencing; an op offered in the forced no-op is dropped
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            second_cycle <= 1'b0;
            second_kind  <= SECOND_NONE;
            op_done      <= 1'b0;
        end else begin
            op_done <= 1'b0;
            if (second_cycle) begin
                second_cycle <= 1'b0;
                second_kind  <= SECOND_NONE;
                op_done      <= 1'b1;
            end else if (accept) begin
                if (next_second_kind != SECOND_NONE) begin
                    second_cycle <= 1'b1;
                    second_kind  <= next_second_kind;
                end else begin
                    op_done <= 1'b1;
                end
            end
        end
    end

    // Stack pointer wraps silently past the last level, like the
    // hardware stack it models; no overflow indication exists
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stack_ptr   <= {STACK_PTR_W{1'b0}};
            stack_level <= {STACK_PTR_W{1'b0}};
        end else if (next_push) begin
            stack_ptr   <= stack_ptr + `STACK_PTR_STEP;
            stack_level <= stack_ptr + `STACK_PTR_STEP;
        end
    end

    // Return stack storage; stack_top is its registered read data
    return_stack_mem #(
        .WIDTH  (`PC_W),
        .DEPTH  (STACK_DEPTH),
        .ADDR_W (STACK_PTR_W)
    ) u_stack (
        .clk     (clk),
        .resetn  (resetn),
        .wr_en   (next_push),
        .wr_addr (stack_ptr),
        .wr_data (return_addr),
        .rd_addr (stack_rd_addr),
        .rd_data (stack_top)
    );

endmodule // instr_exec_core

// ===== sim/instr_exec_core_props.sv
// Concurrent checks on the execution core ports.
// Assumes one clock domain, clk with resetn, bound to every core instance.
`timescale 1ns/1ns
`include "instr_exec_regs.vh"

module instr_exec_core_props (
    input wire                      clk,
    input wire                      resetn,
    input wire                      op_valid,
    input wire [2:0]                op_sel,
    input wire                      dest_bit,
    input wire [`DATA_W-1:0]        file_rd_data,
    input wire [`CALL_TARGET_W-1:0] call_target,
    input wire [`PC_LATCH_W-1:0]    pc_high_latch,
    input wire [`DATA_W-1:0]        working_accumulator,
    input wire                      file_wr_en,
    input wire [`DATA_W-1:0]        file_wr_data,
    input wire                      zero_flag,
    input wire                      timeout_flag,
    input wire                      powerdown_flag,
    input wire                      watchdog_clear,
    input wire [`PC_W-1:0]          program_counter,
    input wire [`PC_W-1:0]          stack_top,
    input wire                      second_cycle,
    input wire                      op_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Taken only outside the discarded slot
    wire       tk       = op_valid && !second_cycle;
    wire [1:0] latch_hi = pc_high_latch[4:3];

    property p_watchdog;
        tk && op_sel == `OP_CLEAR_WATCHDOG |=> watchdog_clear && timeout_flag && powerdown_flag
            && $stable(zero_flag);
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog clear result wrong");
    property p_call_pc;
        tk && op_sel == `OP_CALL |=> program_counter == {$past(latch_hi), $past(call_target)};
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("call target wrong");
    property p_call_push;
        tk && op_sel == `OP_CALL |=> stack_top == $past(program_counter) + `PC_STEP;
    endproperty
    a_call_push: assert property (p_call_push) else $error("return address wrong");
    property p_call_two;
        tk && op_sel == `OP_CALL |=> second_cycle && $stable(zero_flag) ##1 !second_cycle && op_done;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call length wrong");
    property p_comp;
        tk && op_sel == `OP_COMPLEMENT_REG && dest_bit |=> file_wr_en
            && file_wr_data == ~$past(file_rd_data) && zero_flag == (file_wr_data == `DATA_ZERO);
    endproperty
    a_comp: assert property (p_comp) else $error("complement wrong");
    property p_clear_reg;
        tk && op_sel == `OP_CLEAR_REG |=> file_wr_en && file_wr_data == `DATA_ZERO && zero_flag;
    endproperty
    a_clear_reg: assert property (p_clear_reg) else $error("clear register wrong");
    property p_clear_accum;
        tk && op_sel == `OP_CLEAR_ACCUM |=> working_accumulator == `DATA_ZERO && zero_flag;
    endproperty
    a_clear_accum: assert property (p_clear_accum) else $error("clear accumulator wrong");
    property p_dec;
        tk && op_sel == `OP_DECREMENT_REG && !dest_bit |=> !file_wr_en
            && working_accumulator == $past(file_rd_data) - `DATA_ONE
            && zero_flag == (working_accumulator == `DATA_ZERO);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");
    property p_skip;
        tk && op_sel == `OP_DECREMENT_SKIP |=> $stable(zero_flag)
            && second_cycle == ($past(file_rd_data) == `DATA_ONE);
    endproperty
    a_skip: assert property (p_skip) else $error("skip decision wrong");

    // Main scenarios reached
    c_call: cover property (tk && op_sel == `OP_CALL);
    c_skip: cover property (tk && op_sel == `OP_DECREMENT_SKIP && file_rd_data == `DATA_ONE);
    c_drop: cover property (op_valid && second_cycle);
endmodule // instr_exec_core_props

bind instr_exec_core instr_exec_core_props instr_exec_core_props_i (
    .clk(clk), .resetn(resetn), .op_valid(op_valid), .op_sel(op_sel), .dest_bit(dest_bit),
    .file_rd_data(file_rd_data), .call_target(call_target), .pc_high_latch(pc_high_latch),
    .working_accumulator(working_accumulator), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data), .zero_flag(zero_flag), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .watchdog_clear(watchdog_clear),
    .program_counter(program_counter), .stack_top(stack_top),
    .second_cycle(second_cycle), .op_done(op_done)
);

// ===== sim/core_instr_exec_subset_tb_top.sv
// Self-checking bench for the execution core, driving its operation port.
// Assumes a 250 MHz clock; ops issued 1 ns after the rising edge.
`timescale 1ns/1ns
`include "instr_exec_regs.vh"

module core_instr_exec_subset_tb_top;
    reg         clk = 0, resetn = 0, op_valid = 0, dest_bit = 0;
    reg  [2:0]  op_sel = 0;
    reg  [6:0]  file_addr = 7'h55;
    reg  [7:0]  file_rd_data = 0;
    reg  [10:0] call_target = 0;
    reg  [4:0]  pc_high_latch = 0;
    wire [7:0]  acc, wr_data;
    wire [6:0]  wr_addr;
    wire [12:0] pc, stack_top;
    wire [2:0]  level;
    wire        wr_en, zf, tof, pdf, wdc, sec, done;
    integer     n_fail = 0, compares = 0;

    always #2 clk = ~clk;

    instr_exec_core instr_exec_core_i (
        .clk(clk), .resetn(resetn), .op_valid(op_valid), .op_sel(op_sel),
        .dest_bit(dest_bit), .file_addr(file_addr), .file_rd_data(file_rd_data),
        .call_target(call_target), .pc_high_latch(pc_high_latch),
        .working_accumulator(acc), .file_wr_en(wr_en), .file_wr_addr(wr_addr),
        .file_wr_data(wr_data), .zero_flag(zf), .timeout_flag(tof), .powerdown_flag(pdf),
        .watchdog_clear(wdc), .program_counter(pc), .stack_top(stack_top),
        .stack_level(level), .second_cycle(sec), .op_done(done)
    );

    // One op per cycle; returns once the taking edge has landed
    task op(input v, input [2:0] s, input d, input [7:0] fd);
        begin
            op_valid = v; op_sel = s; dest_bit = d; file_rd_data = fd;
            @(posedge clk); #1;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task end_sim;
        begin
            $display("compares %0d n_fail %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask

    // Hang guard, far beyond the few dozen cycles of the run
    initial begin
        #2000;
        n_fail = n_fail + 1;
        end_sim;
    end

    // Each result checked 1 ns after the edge that takes its op
    initial begin
        repeat (10) @(posedge clk);
        #1 resetn = 1;
        chk({tof, pdf, zf, pc, level, sec}, 20'hC0000);
        op(1, `OP_DECREMENT_REG, 0, 8'h01); chk({acc, zf}, 9'h001);
        chk(stack_top, 13'h0000);
        op(1, `OP_COMPLEMENT_REG, 0, 8'h0F); chk({acc, zf}, 9'h1E0);
        op(1, `OP_CLEAR_REG, 0, 8'h3C); chk({wr_en, wr_data, zf}, 10'h201);
        chk(wr_addr, 7'h55);
        op(1, `OP_DECREMENT_REG, 1, 8'h00); chk({wr_en, wr_data, acc}, 17'h1FFF0);
        chk(zf, 0);
        op(1, `OP_CLEAR_WATCHDOG, 0, 8'h00); chk({wdc, tof, pdf, zf}, 4'hE);
        op(1, `OP_CLEAR_ACCUM, 1, 8'h77); chk({wr_en, acc, zf}, 10'h001);
        // Top of page: target 2047 under latch page 3
        call_target = 11'h7FF; pc_high_latch = 5'h18;
        op(1, `OP_CALL, 0, 8'h00); chk(pc, 13'h1FFF);
        chk(stack_top, 13'h0007);
        chk({sec, level, zf}, 5'h13);
        op(0, `OP_NO_OPERATION, 0, 8'h00); chk({sec, done, zf}, 3'h3);
        // Return address wraps past the 13-bit space
        call_target = 11'h000; pc_high_latch = 5'h08;
        op(1, `OP_CALL, 0, 8'h00); chk({pc, stack_top}, 26'h1000000);
        chk(level, 3'h2);
        op(0, `OP_NO_OPERATION, 0, 8'h00);
        op(1, `OP_DECREMENT_SKIP, 0, 8'h05); chk({acc, sec, zf}, 10'h011);
        chk(pc, 13'h0801);
        op(1, `OP_DECREMENT_SKIP, 1, 8'h01); chk({sec, wr_en, wr_data}, 10'h300);
        // Offered in the discarded slot, must have no effect
        op(1, `OP_DECREMENT_REG, 0, 8'h10); chk({acc, zf}, 9'h009);
        chk(pc, 13'h0803);
        op(1, `OP_COMPLEMENT_REG, 1, 8'hFF); chk({wr_en, wr_data, zf}, 10'h201);
        op(1, `OP_NO_OPERATION, 0, 8'h00); chk({pc, done, sec}, 15'h2016);
        op(0, `OP_NO_OPERATION, 0, 8'h00);
        end_sim;
    end
endmodule // core_instr_exec_subset_tb_top
